// ### rtl/hlc_cfg.svh
`ifndef HLC_CFG_SVH
`define HLC_CFG_SVH

// register byte offsets
`define HLC_OFS_CTRL_ZERO 8'h00
`define HLC_OFS_CTRL_ONE 8'h04
`define HLC_OFS_LINK_STATUS 8'h08

// host_link_control_zero field positions
`define HLC_Z_CTRL_IRQ_EN 0
`define HLC_Z_SYS_MGMT_EN 1
`define HLC_Z_WAKE_EN 2
`define HLC_Z_HW_SDWN_EN 3
`define HLC_Z_WMASK 8'h0F

// host_link_control_one field positions
`define HLC_O_CTRL_IRQ_BIT 0
`define HLC_O_SYS_MGMT_BIT 1
`define HLC_O_WAKE_BIT 2
`define HLC_O_SOFT_SDWN 3
`define HLC_O_SOFT_RST 4
`define HLC_O_IRQ_BUSY 5

// link status field positions
`define HLC_S_HW_RESET 0
`define HLC_S_HW_SDWN 1
`define HLC_S_PWR_DOWN 2
`define HLC_S_ARM_RST 3
`define HLC_S_ARM_SDWN 4

// reset values
`define HLC_CTRL_ZERO_RST 8'h00
`define HLC_OUT_BITS_RST 3'h0

`endif

// ### rtl/hlc_pkg.sv
package hlc_pkg;
  // axi response codes
  typedef enum logic [1:0] {
    HLC_RESP_OKAY = 2'b00,
    HLC_RESP_SLVERR = 2'b10
  } hlc_resp_t;
  // register word of the bank
  typedef logic [31:0] hlc_word_t;
endpackage

// ### rtl/hlc_reg_if.sv
`timescale 1ns/1ps
// register access strobes between bus slave and bank
interface hlc_reg_if #(parameter int ADDR_W = 8);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_err, rd_data, rd_err);
  modport bank (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_err, rd_data, rd_err);
endinterface

// ### rtl/hlc_axil_slave.sv
`timescale 1ns/1ps
module hlc_axil_slave import hlc_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address and data
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // bank side
  hlc_reg_if.slv rif
);

  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire aw_take;
  wire w_take;
  wire ar_take;

  // handshakes; a channel is closed while its item is held or its response waits
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign ar_take = arvalid && arready;

  // write strobe once both halves are held
  assign rif.wr_en = aw_held_r && w_held_r && !bvalid_r;
  assign rif.wr_addr = awaddr_r;
  assign rif.wr_data = wdata_r;
  assign rif.wr_strb = wstrb_r;
  assign rif.rd_en = ar_take;
  assign rif.rd_addr = araddr;

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (rif.wr_en) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= HLC_RESP_OKAY;
    end else if (rif.wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r <= rif.wr_err ? HLC_RESP_SLVERR : HLC_RESP_OKAY;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= HLC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rif.rd_data;
      rresp_r <= rif.rd_err ? HLC_RESP_SLVERR : HLC_RESP_OKAY;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // hlc_axil_slave

// ### rtl/hlc_ctrl_bank.sv
`timescale 1ns/1ps
`include "hlc_cfg.svh"

module hlc_ctrl_bank import hlc_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // link events from the transfer logic
  input wire logic serirq_frame_start,
  input wire logic serirq_frame_end,
  input wire logic lpc_hw_reset,
  input wire logic power_down_input_n,
  // host interface state
  output logic host_if_soft_reset,
  output logic host_if_soft_shutdown,
  output logic host_if_reset,
  output logic host_if_shutdown,
  // other pin functions, order wake, sys mgmt, ctrl irq
  input wire logic [2:0] alt_func_o,
  input wire logic [2:0] alt_func_oe,
  output logic [2:0] alt_func_sel,
  // open-drain sideband pins
  output logic wake_event_pin_o,
  output logic wake_event_pin_oe,
  output logic sys_mgmt_irq_pin_o,
  output logic sys_mgmt_irq_pin_oe,
  output logic ctrl_irq_pin_o,
  output logic ctrl_irq_pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // parameter check

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
    $error("hlc_ctrl_bank: ADDR_W must lie in 4..32");
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  hlc_reg_if #(.ADDR_W(ADDR_W)) rif ();

  hlc_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif)
  );

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] ctrl_zero_r;
  logic [2:0] out_bits_r;
  logic [2:0] out_bits_nxt;
  logic soft_reset_bit_r;
  logic soft_reset_bit_nxt;
  logic soft_shutdown_bit_r;
  logic soft_shutdown_bit_nxt;
  logic serial_irq_busy_flag_r;
  logic serial_irq_busy_flag_nxt;
  logic arm_rst_r;
  logic arm_rst_nxt;
  logic arm_sdwn_r;
  logic arm_sdwn_nxt;
  logic pd_n_prev_r;

  ////////////////////////////////////////////////////////////////////////
  // decode

  wire [ADDR_W-1:0] ofs_zero = ADDR_W'(`HLC_OFS_CTRL_ZERO);
  wire [ADDR_W-1:0] ofs_one = ADDR_W'(`HLC_OFS_CTRL_ONE);
  wire [ADDR_W-1:0] ofs_stat = ADDR_W'(`HLC_OFS_LINK_STATUS);
  wire wr_lane0 = rif.wr_en && rif.wr_strb[0];
  wire wr_zero = wr_lane0 && (rif.wr_addr == ofs_zero);
  wire wr_one = wr_lane0 && (rif.wr_addr == ofs_one);
  wire wr_hit = (rif.wr_addr == ofs_zero) || (rif.wr_addr == ofs_one) ||
    (rif.wr_addr == ofs_stat);
  wire rd_is_zero = rif.rd_addr == ofs_zero;
  wire rd_is_one = rif.rd_addr == ofs_one;
  wire rd_is_stat = rif.rd_addr == ofs_stat;
  wire rd_one = rif.rd_en && rd_is_one;
  wire [7:0] wbyte = rif.wr_data[7:0];

  // link conditions
  wire hw_shutdown_enable = ctrl_zero_r[`HLC_Z_HW_SDWN_EN];
  wire hw_shutdown = hw_shutdown_enable && !power_down_input_n;
  wire hw_sdwn_release = hw_shutdown_enable == 1'b0 &&
    power_down_input_n && !pd_n_prev_r;
  wire any_reset = lpc_hw_reset || soft_reset_bit_r;
  wire any_shutdown = hw_shutdown || soft_shutdown_bit_r;

  // status words
  wire [7:0] ctrl_one_rd = {2'b00, serial_irq_busy_flag_r,
    soft_reset_bit_r, soft_shutdown_bit_r, out_bits_r};
  wire [7:0] stat_rd = {3'b000, arm_sdwn_r, arm_rst_r, !power_down_input_n,
    hw_shutdown, lpc_hw_reset};

  // read mux and error answers
  assign rif.rd_data = rd_is_zero ? {24'h0, ctrl_zero_r} :
    rd_is_one ? {24'h0, ctrl_one_rd} :
    rd_is_stat ? {24'h0, stat_rd} : 32'h0;
  assign rif.rd_err = !(rd_is_zero || rd_is_one || rd_is_stat);
  assign rif.wr_err = !wr_hit;

  ////////////////////////////////////////////////////////////////////////
  // serial interrupt busy flag

  always_comb begin
    serial_irq_busy_flag_nxt = serial_irq_busy_flag_r;
    if (serirq_frame_start) begin
      serial_irq_busy_flag_nxt = 1'b1;
    end else if (serirq_frame_end) begin
      serial_irq_busy_flag_nxt = 1'b0;
    end
    if (any_reset || any_shutdown) begin
      serial_irq_busy_flag_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // soft reset bit with read-before-write arming

  always_comb begin
    soft_reset_bit_nxt = soft_reset_bit_r;
    arm_rst_nxt = arm_rst_r;
    if (wr_one) begin
      arm_rst_nxt = 1'b0;
      if (!wbyte[`HLC_O_SOFT_RST]) begin
        soft_reset_bit_nxt = 1'b0;
      end else if (arm_rst_r) begin
        soft_reset_bit_nxt = 1'b1;
      end
    end
    if (rd_one) begin
      arm_rst_nxt = !soft_reset_bit_r;
    end
    if (lpc_hw_reset) begin
      soft_reset_bit_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // soft shutdown bit with read-before-write arming

  always_comb begin
    soft_shutdown_bit_nxt = soft_shutdown_bit_r;
    arm_sdwn_nxt = arm_sdwn_r;
    if (wr_one) begin
      arm_sdwn_nxt = 1'b0;
      if (!wbyte[`HLC_O_SOFT_SDWN]) begin
        soft_shutdown_bit_nxt = 1'b0;
      end else if (arm_sdwn_r) begin
        soft_shutdown_bit_nxt = 1'b1;
      end
    end
    if (rd_one) begin
      arm_sdwn_nxt = !soft_shutdown_bit_r;
    end
    if (any_reset || hw_shutdown || hw_sdwn_release) begin
      soft_shutdown_bit_nxt = 1'b0;
    end
  end

  // output bits; busy flag field of the write is dropped
  assign out_bits_nxt = wr_one ? wbyte[2:0] : out_bits_r;

  ////////////////////////////////////////////////////////////////////////
  // registers

  // control zero holds the pin enables and the shutdown enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_zero_r <= `HLC_CTRL_ZERO_RST;
    end else if (wr_zero) begin
      ctrl_zero_r <= wbyte & `HLC_Z_WMASK;
    end
  end

  // control one fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_bits_r <= `HLC_OUT_BITS_RST;
      soft_reset_bit_r <= 1'b0;
      soft_shutdown_bit_r <= 1'b0;
      serial_irq_busy_flag_r <= 1'b0;
    end else begin
      out_bits_r <= out_bits_nxt;
      soft_reset_bit_r <= soft_reset_bit_nxt;
      soft_shutdown_bit_r <= soft_shutdown_bit_nxt;
      serial_irq_busy_flag_r <= serial_irq_busy_flag_nxt;
    end
  end

  // arming flags and power-down edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_rst_r <= 1'b0;
      arm_sdwn_r <= 1'b0;
      pd_n_prev_r <= 1'b1;
    end else begin
      arm_rst_r <= arm_rst_nxt;
      arm_sdwn_r <= arm_sdwn_nxt;
      pd_n_prev_r <= power_down_input_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host interface state outputs

  assign host_if_soft_reset = soft_reset_bit_r;
  assign host_if_soft_shutdown = soft_shutdown_bit_r;
  assign host_if_reset = any_reset;
  assign host_if_shutdown = any_shutdown;

  ////////////////////////////////////////////////////////////////////////
  // open-drain sideband pins, index 0 ctrl irq, 1 sys mgmt, 2 wake

  logic [2:0] pin_o;
  logic [2:0] pin_oe;
  wire [2:0] pin_en = {ctrl_zero_r[`HLC_Z_WAKE_EN],
    ctrl_zero_r[`HLC_Z_SYS_MGMT_EN], ctrl_zero_r[`HLC_Z_CTRL_IRQ_EN]};

  for (genvar i = 0; i < 3; i++) begin : g_pin
    // enabled: drive low for bit 0, float for bit 1
    assign pin_o[i] = pin_en[i] ? 1'b0 : alt_func_o[i];
    assign pin_oe[i] = pin_en[i] ? !out_bits_r[i] : alt_func_oe[i];
    assign alt_func_sel[i] = !pin_en[i];
  end

  assign wake_event_pin_o = pin_o[`HLC_O_WAKE_BIT];
  assign wake_event_pin_oe = pin_oe[`HLC_O_WAKE_BIT];
  assign sys_mgmt_irq_pin_o = pin_o[`HLC_O_SYS_MGMT_BIT];
  assign sys_mgmt_irq_pin_oe = pin_oe[`HLC_O_SYS_MGMT_BIT];
  assign ctrl_irq_pin_o = pin_o[`HLC_O_CTRL_IRQ_BIT];
  assign ctrl_irq_pin_oe = pin_oe[`HLC_O_CTRL_IRQ_BIT];

endmodule // hlc_ctrl_bank

// ### tb/hlc_lpc_host.sv
`timescale 1ns/1ps
// far side: frame events and the other pin function
module hlc_lpc_host #(
  parameter int FRAME_LEN = 30
) (
  // clock and command
  input wire logic aclk,
  input wire logic go,
  // frame events
  output logic frame_start = 1'b0,
  output logic frame_end = 1'b0,
  // other function drive, changes every cycle
  output logic [2:0] alt_o,
  output logic [2:0] alt_oe
);
  int cnt_r = 0;
  logic [2:0] pat_r = 3'h0;
  // one start pulse, end pulse after the frame length
  always_ff @(posedge aclk) begin
    frame_start <= go;
    frame_end <= (cnt_r == 1);
    cnt_r <= go ? FRAME_LEN : (cnt_r > 0 ? cnt_r - 1 : 0);
    pat_r <= pat_r + 3'h1;
  end
  assign alt_o = pat_r;
  assign alt_oe = ~pat_r;
endmodule // hlc_lpc_host

// ### tb/hlc_ctrl_bank_checker.sv
`timescale 1ns/1ps
// port checks of the control bank
module hlc_ctrl_bank_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus and link
  input wire logic bvalid,
  input wire logic lpc_hw_reset,
  // host interface state
  input wire logic host_if_soft_reset,
  input wire logic host_if_soft_shutdown,
  input wire logic host_if_reset,
  input wire logic host_if_shutdown,
  // pins
  input wire logic [2:0] alt_func_o,
  input wire logic [2:0] alt_func_oe,
  input wire logic [2:0] alt_func_sel,
  input wire logic wake_event_pin_o,
  input wire logic sys_mgmt_irq_pin_o,
  input wire logic ctrl_irq_pin_o,
  input wire logic ctrl_irq_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rst_comb: assert property (host_if_reset ==
    (lpc_hw_reset | host_if_soft_reset)) else $error("reset mix");
  a_rst_set: assert property ($rose(host_if_soft_reset)
    |-> $rose(bvalid)) else $error("soft reset set without write");
  a_hw_clr: assert property (lpc_hw_reset
    |=> !host_if_soft_reset && !host_if_soft_shutdown)
    else $error("hw reset did not clear");
  a_sdwn_set: assert property ($rose(host_if_soft_shutdown)
    |-> $rose(bvalid)) else $error("shutdown set without write");
  a_sdwn_lvl: assert property (host_if_soft_shutdown
    |-> host_if_shutdown) else $error("shutdown level");
  a_ctrl_alt: assert property (alt_func_sel[0] |->
    ctrl_irq_pin_o == alt_func_o[0] && ctrl_irq_pin_oe == alt_func_oe[0])
    else $error("ctrl pin not given away");
  a_ctrl_low: assert property (!alt_func_sel[0] |->
    !ctrl_irq_pin_o) else $error("ctrl pin drives high");
  a_sys_low: assert property (!alt_func_sel[1] |->
    !sys_mgmt_irq_pin_o) else $error("sys pin drives high");
  a_wake_low: assert property (!alt_func_sel[2] |->
    !wake_event_pin_o) else $error("wake pin drives high");
  a_sel_write: assert property (!$stable(alt_func_sel)
    |-> $rose(bvalid)) else $error("select moved without write");
endmodule // hlc_ctrl_bank_checker

bind hlc_ctrl_bank hlc_ctrl_bank_checker u_chk (.aclk(aclk),
  .aresetn(aresetn), .bvalid(bvalid), .lpc_hw_reset(lpc_hw_reset),
  .host_if_soft_reset(host_if_soft_reset),
  .host_if_soft_shutdown(host_if_soft_shutdown),
  .host_if_reset(host_if_reset), .host_if_shutdown(host_if_shutdown),
  .alt_func_o(alt_func_o), .alt_func_oe(alt_func_oe),
  .alt_func_sel(alt_func_sel), .wake_event_pin_o(wake_event_pin_o),
  .sys_mgmt_irq_pin_o(sys_mgmt_irq_pin_o),
  .ctrl_irq_pin_o(ctrl_irq_pin_o), .ctrl_irq_pin_oe(ctrl_irq_pin_oe));

// ### tb/tb_hlc_ctrl_bank.sv
`timescale 1ns/1ps
module tb_hlc_ctrl_bank;
  import hlc_pkg::*;
  logic aclk = 0, aresetn = 0, go = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, ld;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, f_start, f_end;
  logic [1:0] bresp, rresp, lr;
  logic lpc_hw_reset = 0, pd_n = 1, s_rst, s_sd, h_rst, h_sd;
  logic [2:0] alt_o, alt_oe, alt_sel, pin_o, pin_oe;
  int n_fail = 0, cmp_count = 0;
  always #50 aclk = ~aclk;
  hlc_lpc_host u_hlc_lpc_host (.aclk(aclk), .go(go), .frame_start(f_start),
    .frame_end(f_end), .alt_o(alt_o), .alt_oe(alt_oe));
  hlc_ctrl_bank u_hlc_ctrl_bank (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serirq_frame_start(f_start), .serirq_frame_end(f_end),
    .lpc_hw_reset(lpc_hw_reset), .power_down_input_n(pd_n),
    .host_if_soft_reset(s_rst), .host_if_soft_shutdown(s_sd),
    .host_if_reset(h_rst), .host_if_shutdown(h_sd), .alt_func_o(alt_o),
    .alt_func_oe(alt_oe), .alt_func_sel(alt_sel),
    .wake_event_pin_o(pin_o[2]), .wake_event_pin_oe(pin_oe[2]),
    .sys_mgmt_irq_pin_o(pin_o[1]), .sys_mgmt_irq_pin_oe(pin_oe[1]),
    .ctrl_irq_pin_o(pin_o[0]), .ctrl_irq_pin_oe(pin_oe[0]));
  ////////////////////////////////////////////////////////////////////////
  // bus write, response kept in lr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    lr = bresp;
  endtask
  // bus read, data in ld and response in lr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    ld = rdata;
    lr = rresp;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, string n);
    rd(a);
    chk(n, e, ld);
  endtask
  // one-cycle pulse on a tb line
  task automatic hw_rst();
    lpc_hw_reset <= 1'b1;
    @(posedge aclk);
    lpc_hw_reset <= 1'b0;
  endtask
  task automatic frame();
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    cyc(5000);
    n_fail++;
    $display("watchdog expired");
    end_sim();
  end
  // test sequence
  initial begin
    cyc(4);
    aresetn <= 1'b1;
    rdc(8'h00, 0, "ctrl_zero");
    rdc(8'h04, 0, "ctrl_one");
    chk("sel", 3'h7, alt_sel);
    $display("test reset done");
    wr(8'h04, 32'h00);
    wr(8'h04, 32'h10);
    chk("rst_noarm", 0, s_rst);
    rd(8'h04);
    wr(8'h04, 32'h10);
    chk("rst_set", 1, h_rst);
    wr(8'h04, 32'h00);
    chk("rst_clr", 0, s_rst);
    rd(8'h04);
    wr(8'h04, 32'h10);
    hw_rst();
    rdc(8'h04, 0, "rst_hw");
    $display("test soft reset done");
    rd(8'h04);
    wr(8'h04, 32'h08);
    pd_n <= 1'b0;
    cyc(3);
    chk("sd_hold", 1, s_sd);
    pd_n <= 1'b1;
    cyc(3);
    chk("sd_release", 0, s_sd);
    wr(8'h00, 32'h08);
    rd(8'h04);
    wr(8'h04, 32'h08);
    pd_n <= 1'b0;
    cyc(3);
    chk("sd_hw", 0, s_sd);
    chk("hw_sd", 1, h_sd);
    pd_n <= 1'b1;
    wr(8'h00, 32'h00);
    rd(8'h04);
    wr(8'h04, 32'h08);
    rd(8'h04);
    wr(8'h04, 32'h18);
    rdc(8'h04, 32'h10, "sd_softrst");
    wr(8'h04, 32'h00);
    $display("test shutdown done");
    frame();
    rdc(8'h04, 32'h20, "busy_set");
    wr(8'h04, 32'h00);
    rdc(8'h04, 32'h20, "busy_ro");
    cyc(30);
    wr(8'h04, 32'h20);
    rdc(8'h04, 0, "busy_end");
    frame();
    rdc(8'h04, 32'h20, "busy_pre");
    hw_rst();
    rdc(8'h04, 0, "busy_rst");
    $display("test busy done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'h1 << i);
      wr(8'h04, 32'h00);
      chk("pin_oe_low", 1, pin_oe[i]);
      chk("pin_o_low", 0, pin_o[i]);
      wr(8'h04, 32'h1 << i);
      chk("pin_oe_hiz", 0, pin_oe[i]);
      rdc(8'h04, 32'h1 << i, "out_bit");
      chk("sel", ~(32'h1 << i) & 32'h7, alt_sel);
    end
    $display("test pins done");
    rd(8'h0C);
    chk("rresp", HLC_RESP_SLVERR, lr);
    wr(8'h0C, 32'h00);
    chk("bresp", HLC_RESP_SLVERR, lr);
    $display("test unmapped done");
    end_sim();
  end
endmodule // tb_hlc_ctrl_bank
